/* File: logic/vdsv_pkg.sv */
`default_nettype none

package vdsv_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ACK_LOW     = 8'h7E;
  localparam logic [7:0] OFS_ACK_HIGH    = 8'h7F;
  localparam logic [7:0] OFS_VERSION     = 8'h80;
  localparam logic [7:0] OFS_LOCK_STD    = 8'h81;
  localparam logic [7:0] OFS_SOURCE_DET  = 8'h82;
  localparam logic [7:0] OFS_NOISE_LVL   = 8'h83;
  localparam logic [7:0] OFS_SLICER_LVL  = 8'h84;
  localparam logic [7:0] OFS_SLICER_FILT = 8'h85;
  localparam logic [7:0] OFS_VBI_DET     = 8'h86;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MAIN_CTRL   = 8'h04;
  localparam logic [7:0] RST_ACK_LOW     = 8'h00;
  localparam logic [7:0] RST_ACK_HIGH    = 8'h00;
  localparam int         POS_VSYNC_TYPE  = 7;
  localparam int         ACK_HIGH_BITS   = 2;

  // decoder version code, value arbitrary
  localparam logic [7:0] DECODER_VERSION_CODE = 8'hA5;

  // ----------------------------------------------------------------
  // two-wire bus
  // ----------------------------------------------------------------
  localparam logic [6:0] DEVICE_ADDR     = 7'h2C;
  localparam logic [3:0] BIT_ACK_SLOT    = 4'h8;
  localparam logic [3:0] BIT_LAST_DATA   = 4'h7;

  // ----------------------------------------------------------------
  // vertical sync line numbers and standard codes
  // ----------------------------------------------------------------
  localparam logic [9:0] LINE_FIRST      = 10'h001;
  localparam logic [9:0] LINE_MID_525    = 10'h107;
  localparam logic [9:0] LINE_MID_625    = 10'h139;
  localparam logic [9:0] LINE_DIG_SECOND = 10'h108;
  localparam logic [2:0] OUT_STD_2       = 3'h2;
  localparam logic [2:0] OUT_STD_3       = 3'h3;

  // bus slave states
  typedef enum logic [2:0] {
    VDSV_IDLE,
    VDSV_ADDR,
    VDSV_PTR,
    VDSV_WR,
    VDSV_RD
  } vdsv_bus_state_t;

endpackage

`default_nettype wire

/* File: logic/vdsv_vsync_gen.sv */
`timescale 1ns/1ps
`default_nettype none

module vdsv_vsync_gen
  import vdsv_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       line_start,
  input  wire logic       line_middle,
  input  wire logic       frame_start,
  input  wire logic [2:0] output_standard,
  input  wire logic       vsync_insertion_type,
  input  wire logic       analog_vsync_variant_control,
  input  wire logic       input_interlaced,
  output logic            vsync_out
);

  logic [9:0] line_cnt_reg;
  logic [9:0] line_next;
  logic [9:0] second_line;
  logic       interlaced;
  logic       toggle;
  logic       vsync_reg;

  // ----------------------------------------------------------------
  // line counting
  // ----------------------------------------------------------------
  // number of the line that begins on this cycle
  assign line_next = frame_start ? LINE_FIRST : 10'(line_cnt_reg + 10'h001);

  // counter follows the line pulses of the output timing
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      line_cnt_reg <= 10'h000;
    else if (line_start)
      line_cnt_reg <= line_next;
  end

  // ----------------------------------------------------------------
  // toggle decision
  // ----------------------------------------------------------------
  // 625-line standards use 313, every other code the 525-line figure
  assign second_line = (output_standard == OUT_STD_2 || output_standard == OUT_STD_3) ?
                       LINE_MID_625 : LINE_MID_525;

  // follow the input unless interlace is forced
  assign interlaced = analog_vsync_variant_control | input_interlaced;

  always_comb
  begin
    if (vsync_insertion_type)
      toggle = line_start && (line_next == LINE_FIRST || line_next == LINE_DIG_SECOND);
    else if (interlaced)
      toggle = (line_start && line_next == LINE_FIRST) ||
               (line_middle && !line_start && line_cnt_reg == second_line);
    else
      toggle = line_start && (line_next == LINE_FIRST || line_next == second_line);
  end

  // one flop on the output clock, so edges stay aligned to it
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      vsync_reg <= 1'b0;
    else if (toggle)
      vsync_reg <= ~vsync_reg;
  end

  assign vsync_out = vsync_reg;

endmodule

`default_nettype wire

/* File: logic/vdsv_regbank.sv */
`timescale 1ns/1ps
`default_nettype none

module vdsv_regbank
  import vdsv_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // two-wire serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // decoder core status, same clock
  input  wire logic       vertical_lock_flag,
  input  wire logic       horizontal_lock_flag,
  input  wire logic       clock_pll_lock_flag,
  input  wire logic       field_rate_identification,
  input  wire logic       standard_identified_flag,
  input  wire logic [2:0] detected_standard_code,
  input  wire logic [7:0] source_detection,
  input  wire logic [7:0] noise_level,
  input  wire logic [7:0] slicer_level,
  input  wire logic [7:0] slicer_filter,
  input  wire logic [6:0] vbi_detection,
  // output timing, same clock
  input  wire logic       line_start,
  input  wire logic       line_middle,
  input  wire logic       frame_start,
  input  wire logic [2:0] output_standard,
  input  wire logic       input_interlaced,
  input  wire logic       analog_vsync_variant_control,
  // outputs
  output logic [7:0]      main_control,
  output logic [7:0]      event_ack_low,
  output logic [1:0]      event_ack_high,
  output logic            vsync_out
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;

  // two flops before any logic looks at the pins
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  // edges seen only on the second stage
  assign scl_rise   = scl_sync_reg[1] && !scl_prev_reg;
  assign scl_fall   = !scl_sync_reg[1] && scl_prev_reg;
  assign start_cond = scl_sync_reg[1] && scl_prev_reg && !sda_sync_reg[1] && sda_prev_reg;
  assign stop_cond  = scl_sync_reg[1] && scl_prev_reg && sda_sync_reg[1] && !sda_prev_reg;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] main_ctrl_reg;
  logic [7:0] ack_low_reg;
  logic [1:0] ack_high_reg;
  logic       wr_stb_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;

  // writes to read-only offsets are dropped
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      main_ctrl_reg <= RST_MAIN_CTRL;
    else if (wr_stb_reg && wr_addr_reg == OFS_MAIN_CTRL)
      main_ctrl_reg <= wr_data_reg;
  end

  // acknowledge bits are plain storage; the core reads them
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_low_reg  <= RST_ACK_LOW;
      ack_high_reg <= RST_ACK_HIGH[ACK_HIGH_BITS-1:0];
    end
    else if (wr_stb_reg)
    begin
      if (wr_addr_reg == OFS_ACK_LOW)
        ack_low_reg <= wr_data_reg;
      if (wr_addr_reg == OFS_ACK_HIGH)
        ack_high_reg <= wr_data_reg[ACK_HIGH_BITS-1:0];
    end
  end

  assign main_control   = main_ctrl_reg;
  assign event_ack_low  = ack_low_reg;
  assign event_ack_high = ack_high_reg;

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  logic [7:0] ptr_reg;
  logic [7:0] rd_data;

  // status is read live; unmapped offsets read as zero
  always_comb
  begin
    unique case (ptr_reg)
      OFS_MAIN_CTRL:   rd_data = main_ctrl_reg;
      OFS_ACK_LOW:     rd_data = ack_low_reg;
      OFS_ACK_HIGH:    rd_data = {6'h00, ack_high_reg};
      OFS_VERSION:     rd_data = DECODER_VERSION_CODE;
      OFS_LOCK_STD:    rd_data = {vertical_lock_flag, horizontal_lock_flag, clock_pll_lock_flag,
                                  field_rate_identification, standard_identified_flag,
                                  detected_standard_code};
      OFS_SOURCE_DET:  rd_data = source_detection;
      OFS_NOISE_LVL:   rd_data = noise_level;
      OFS_SLICER_LVL:  rd_data = slicer_level;
      OFS_SLICER_FILT: rd_data = slicer_filter;
      OFS_VBI_DET:     rd_data = {1'b0, vbi_detection};
      default:         rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  vdsv_bus_state_t state_reg;
  logic [3:0]      bit_cnt_reg;
  logic [7:0]      shift_reg;
  logic [7:0]      tx_reg;
  logic            is_read_reg;
  logic            matched_reg;
  logic            nack_reg;
  logic            sda_low_reg;

  // sample data on scl rising; the ack slot of a read carries the master answer
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_reg <= 8'h00;
      nack_reg  <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (bit_cnt_reg < BIT_ACK_SLOT)
        shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
      else
        nack_reg <= sda_sync_reg[1];
    end
  end

  // protocol sequencing works on scl falling, when sda may change
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg   <= VDSV_IDLE;
      bit_cnt_reg <= 4'h0;
      ptr_reg     <= 8'h00;
      tx_reg      <= 8'h00;
      is_read_reg <= 1'b0;
      matched_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      wr_stb_reg  <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      wr_stb_reg <= 1'b0;
      if (start_cond)
      begin
        state_reg   <= VDSV_ADDR;
        bit_cnt_reg <= 4'hF; // scl fall closing the start is no data bit; it wraps the count to zero
        sda_low_reg <= 1'b0;
      end
      else if (stop_cond)
      begin
        state_reg   <= VDSV_IDLE;
        sda_low_reg <= 1'b0;
      end
      else if (scl_fall && state_reg != VDSV_IDLE)
      begin
        if (bit_cnt_reg == BIT_LAST_DATA)
        begin
          // entering the ack slot
          bit_cnt_reg <= BIT_ACK_SLOT;
          unique case (state_reg)
            VDSV_ADDR:
            begin
              matched_reg <= (shift_reg[7:1] == DEVICE_ADDR);
              is_read_reg <= shift_reg[0];
              sda_low_reg <= (shift_reg[7:1] == DEVICE_ADDR);
            end
            VDSV_PTR:
            begin
              ptr_reg     <= shift_reg;
              sda_low_reg <= 1'b1;
            end
            VDSV_WR:
            begin
              wr_stb_reg  <= 1'b1;
              wr_addr_reg <= ptr_reg;
              wr_data_reg <= shift_reg;
              ptr_reg     <= 8'(ptr_reg + 8'h01);
              sda_low_reg <= 1'b1;
            end
            VDSV_RD:
            begin
              ptr_reg     <= 8'(ptr_reg + 8'h01);
              sda_low_reg <= 1'b0;
            end
            VDSV_IDLE:
              sda_low_reg <= 1'b0;
          endcase
        end
        else if (bit_cnt_reg == BIT_ACK_SLOT)
        begin
          // leaving the ack slot
          bit_cnt_reg <= 4'h0;
          sda_low_reg <= 1'b0;
          unique case (state_reg)
            VDSV_ADDR:
            begin
              if (!matched_reg)
                state_reg <= VDSV_IDLE;
              else if (is_read_reg)
              begin
                state_reg   <= VDSV_RD;
                tx_reg      <= rd_data;
                sda_low_reg <= !rd_data[7];
              end
              else
                state_reg <= VDSV_PTR;
            end
            VDSV_PTR:
              state_reg <= VDSV_WR;
            VDSV_WR:
              state_reg <= VDSV_WR;
            VDSV_RD:
            begin
              // a master nack ends the read burst
              if (nack_reg)
                state_reg <= VDSV_IDLE;
              else
              begin
                tx_reg      <= rd_data;
                sda_low_reg <= !rd_data[7];
              end
            end
            VDSV_IDLE:
              state_reg <= VDSV_IDLE;
          endcase
        end
        else
        begin
          bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
          if (state_reg == VDSV_RD)
          begin
            tx_reg      <= {tx_reg[6:0], 1'b0};
            sda_low_reg <= !tx_reg[6];
          end
        end
      end
    end
  end

  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = sda_low_reg;

  // ----------------------------------------------------------------
  // vertical sync insertion
  // ----------------------------------------------------------------
  vdsv_vsync_gen u_vsync_gen
  (
    .sys_clk                      (sys_clk),
    .arst_n                       (arst_n),
    .line_start                   (line_start),
    .line_middle                  (line_middle),
    .frame_start                  (frame_start),
    .output_standard              (output_standard),
    .vsync_insertion_type         (main_ctrl_reg[POS_VSYNC_TYPE]),
    .analog_vsync_variant_control (analog_vsync_variant_control),
    .input_interlaced             (input_interlaced),
    .vsync_out                    (vsync_out)
  );

endmodule

`default_nettype wire

/* File: bench/vdsv_chk_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------
// vsync and register checker
// ------------------------------
module vdsv_chk
  import vdsv_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       scl_in,
  input wire logic       line_start,
  input wire logic       line_middle,
  input wire logic       frame_start,
  input wire logic [2:0] output_standard,
  input wire logic       input_interlaced,
  input wire logic       analog_vsync_variant_control,
  input wire logic [7:0] main_control,
  input wire logic [7:0] event_ack_low,
  input wire logic [1:0] event_ack_high,
  input wire logic       vsync_out
);
  logic [9:0] lc;
  logic       seen;
  logic       dig;
  logic       l625;
  logic       ilc;

  // own line count; no line judged before the first frame start
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lc <= 10'h000;
      seen <= 1'h0;
    end
    else if (line_start)
    begin
      lc <= frame_start ? LINE_FIRST : lc + 10'h001;
      seen <= seen | frame_start;
    end
  end

  // decoded mode
  assign dig = main_control[POS_VSYNC_TYPE];
  assign l625 = output_standard inside {OUT_STD_2, OUT_STD_3};
  assign ilc = analog_vsync_variant_control | input_interlaced;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  chk_vs_cause: assert property ($changed(vsync_out) |-> $past(line_start | line_middle))
    else $error("vsync moved off a line event");
  chk_frame_edge: assert property (frame_start |=> $changed(vsync_out))
    else $error("no vsync edge at line one");
  chk_dig_no_mid: assert property (dig && line_middle |=> $stable(vsync_out))
    else $error("digital vsync moved mid line");
  chk_mid_short: assert property (seen && !dig && ilc && !l625 && line_middle && lc == LINE_MID_525
    |=> $changed(vsync_out)) else $error("no mid edge in 525 frame");
  chk_mid_long: assert property (seen && !dig && ilc && l625 && line_middle && lc == LINE_MID_625
    |=> $changed(vsync_out)) else $error("no mid edge in 625 frame");
  chk_dig_second: assert property (seen && dig && line_start && !frame_start
    && lc == LINE_DIG_SECOND - 10'h001 |=> $changed(vsync_out)) else $error("no digital second edge");
  chk_follow_start: assert property (seen && !dig && !ilc && line_start
    && lc == (l625 ? LINE_MID_625 : LINE_MID_525) - 10'h001 |=> $changed(vsync_out))
    else $error("no line start edge when following input");
  chk_reg_scl_low: assert property ($changed({main_control, event_ack_low, event_ack_high}) |-> !scl_in)
    else $error("register changed with bus clock high");
endmodule

bind vdsv_regbank vdsv_chk i_chk
(
  .sys_clk, .arst_n, .scl_in, .line_start, .line_middle, .frame_start, .output_standard, .input_interlaced,
  .analog_vsync_variant_control, .main_control, .event_ack_low, .event_ack_high, .vsync_out
);

`default_nettype wire

/* File: bench/vdsv_far_end.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------
// downstream frame receiver
// ------------------------------
module vdsv_far_end
(
  input  wire logic   sys_clk,
  input  wire logic   arst_n,
  input  wire logic   line_start,
  input  wire logic   line_middle,
  input  wire logic   frame_start,
  input  wire logic   vsync_out,
  output logic [1:0]  toggles,
  output logic [10:0] edge_a,
  output logic [10:0] edge_b
);
  logic [9:0] ln;
  logic       md;
  logic       vq;
  logic [1:0] cnt;

  // logs line and half line of the first vsync edge and of the latest one after it; count saturates to show extras
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ln <= 10'h000;
      md <= 1'h0;
      vq <= 1'h0;
      cnt <= 2'h0;
      toggles <= 2'h0;
      edge_a <= 11'h000;
      edge_b <= 11'h000;
    end
    else
    begin
      vq <= vsync_out;
      md <= line_middle | (md & !line_start);
      if (line_start) ln <= frame_start ? 10'h001 : ln + 10'h001;
      if (frame_start)
      begin
        toggles <= cnt;
        cnt <= 2'h0;
      end
      else if (vsync_out != vq)
      begin
        if (cnt != 2'h3) cnt <= cnt + 2'h1;
        if (cnt == 2'h0) edge_a <= {ln, md};
        else edge_b <= {ln, md};
      end
    end
  end
endmodule

`default_nettype wire

/* File: bench/video_decoder_status_vsync_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module video_decoder_status_vsync_ctrl_tb_top
  import vdsv_pkg::*;
;
  typedef struct packed {logic [2:0] std; logic dig; logic fv; logic il; logic [10:0] eb; logic [9:0] n;} vdsv_row_t;

  logic        sys_clk = 1'h0;
  logic        arst_n = 1'h0;
  logic        scl_in = 1'h1;
  logic        m_pull = 1'h0;
  wire         sda_in;
  logic        sda_out;
  logic        sda_oe;
  logic [7:0]  fl = 8'h00;
  logic [7:0]  st [5] = '{8'h3C, 8'hC3, 8'h5A, 8'hA5, 8'h96};
  logic [2:0]  output_standard = 3'h1;
  logic        input_interlaced = 1'h0;
  logic        analog_vsync_variant_control = 1'h1;
  logic        line_start = 1'h0;
  logic        line_middle = 1'h0;
  logic        frame_start = 1'h0;
  logic [2:0]  pos = 3'h0;
  logic [9:0]  ln = 10'h20D;
  logic [9:0]  n = 10'h20D;
  logic [7:0]  main_control;
  logic [7:0]  event_ack_low;
  logic [1:0]  event_ack_high;
  logic        vsync_out;
  logic [1:0]  toggles;
  logic [10:0] edge_a;
  logic [10:0] edge_b;
  vdsv_row_t   rows [7];
  int          n_errors = 0;
  int          n_checks = 0;

  // open-drain data line: low if either side pulls
  assign sda_in = !(sda_oe | m_pull);

  vdsv_regbank i_dut
  (
    .sys_clk, .arst_n, .scl_in, .sda_in, .sda_out, .sda_oe,
    .vertical_lock_flag(fl[7]), .horizontal_lock_flag(fl[6]), .clock_pll_lock_flag(fl[5]),
    .field_rate_identification(fl[4]), .standard_identified_flag(fl[3]), .detected_standard_code(fl[2:0]),
    .source_detection(st[0]), .noise_level(st[1]), .slicer_level(st[2]), .slicer_filter(st[3]),
    .vbi_detection(st[4][6:0]), .line_start, .line_middle, .frame_start, .output_standard,
    .input_interlaced, .analog_vsync_variant_control, .main_control, .event_ack_low, .event_ack_high, .vsync_out
  );

  vdsv_far_end i_far
  (
    .sys_clk, .arst_n, .line_start, .line_middle, .frame_start, .vsync_out, .toggles, .edge_a, .edge_b
  );

  // clock
  always #2 sys_clk = ~sys_clk;

  // six clocks a line so whole frames fit the run
  always @(posedge sys_clk)
  begin
    pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
    line_middle <= (pos == 3'h2);
    line_start <= (pos == 3'h5);
    frame_start <= (pos == 3'h5) && (ln >= n);
    if (pos == 3'h5) ln <= (ln >= n) ? 10'h001 : ln + 10'h001;
  end

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one bus bit; data moves only while the bus clock is low
  task automatic bitx(input logic b, output logic r);
    m_pull <= !b;
    cyc(8);
    scl_in <= 1'h1;
    cyc(4);
    r = sda_in;
    cyc(4);
    scl_in <= 1'h0;
    cyc(1);
  endtask

  // also a repeated start: let the slave drop its ack before clock rises
  task automatic start_c;
    m_pull <= 1'h0;
    cyc(8);
    scl_in <= 1'h1;
    cyc(8);
    m_pull <= 1'h1;
    cyc(8);
    scl_in <= 1'h0;
    cyc(1);
  endtask

  task automatic stop_c;
    m_pull <= 1'h1;
    cyc(8);
    scl_in <= 1'h1;
    cyc(8);
    m_pull <= 1'h0;
    cyc(8);
  endtask

  task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(m, a);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       k;
    start_c;
    xbyte({DEVICE_ADDR, 1'h0}, 1'h1, q, k);
    xbyte(a, 1'h1, q, k);
    xbyte(d, 1'h1, q, k);
    chk("write ack", k, 1'h0);
    stop_c;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] q);
    logic k;
    start_c;
    xbyte({DEVICE_ADDR, 1'h0}, 1'h1, q, k);
    xbyte(a, 1'h1, q, k);
    start_c;
    xbyte({DEVICE_ADDR, 1'h1}, 1'h1, q, k);
    chk("read ack", k, 1'h0);
    xbyte(8'hFF, 1'h1, q, k);
    stop_c;
  endtask

  task automatic rchk;
    chk("vsync", vsync_out, 1'h0);
    chk("ctrl", main_control, RST_MAIN_CTRL);
    chk("acks", {event_ack_low, event_ack_high}, {RST_ACK_LOW, RST_ACK_HIGH[1:0]});
    chk("sda", sda_oe, 1'h0);
    chk("sda value", sda_out, 1'h0);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog at about one and a half times the expected run of some 60k clocks
  initial
  begin
    #360000;
    n_errors++;
    final_report;
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    logic [7:0] q;
    logic       k;
    rows[0] = '{3'h1, 1'h0, 1'h1, 1'h0, 11'h20F, 10'h20D};
    rows[1] = '{3'h4, 1'h0, 1'h1, 1'h0, 11'h20F, 10'h20D};
    rows[2] = '{3'h2, 1'h0, 1'h1, 1'h0, 11'h273, 10'h271};
    rows[3] = '{3'h3, 1'h0, 1'h1, 1'h0, 11'h273, 10'h271};
    rows[4] = '{3'h2, 1'h1, 1'h1, 1'h0, 11'h210, 10'h271};
    rows[5] = '{3'h1, 1'h0, 1'h0, 1'h0, 11'h20E, 10'h20D};
    rows[6] = '{3'h2, 1'h0, 1'h0, 1'h1, 11'h273, 10'h271};
    cyc(4);
    rchk;
    arst_n <= 1'h1;
    cyc(3);
    foreach (rows[i])
    begin
      output_standard <= rows[i].std;
      analog_vsync_variant_control <= rows[i].fv;
      input_interlaced <= rows[i].il;
      n <= rows[i].n;
      reg_wr(OFS_MAIN_CTRL, {rows[i].dig, 7'h04});
      chk("ctrl", main_control, {rows[i].dig, 7'h04});
      repeat (2) @(posedge sys_clk iff frame_start);
      cyc(1);
      chk("toggles", toggles, 2'h2);
      chk("edge one", edge_a, 11'h002);
      chk("edge two", edge_b, rows[i].eb);
      $display("test row %0d done", i);
    end
    // reset in mid run
    arst_n <= 1'h0;
    cyc(2);
    rchk;
    arst_n <= 1'h1;
    cyc(3);
    $display("test reset done");
    reg_rd(OFS_VERSION, q);
    chk("version", q, DECODER_VERSION_CODE);
    fl <= 8'hA6;
    reg_rd(OFS_LOCK_STD, q);
    chk("lock std", q, 8'hA6);
    fl <= 8'h59;
    reg_wr(OFS_LOCK_STD, 8'hFF);
    reg_rd(OFS_LOCK_STD, q);
    chk("lock std ro", q, 8'h59);
    foreach (st[i]) st[i] <= st[i] ^ 8'hF0;
    for (int i = 0; i < 5; i++)
    begin
      reg_rd(OFS_SOURCE_DET + 8'(i), q);
      chk("status", q, (i == 4) ? {1'h0, st[4][6:0]} : st[i]);
    end
    // read burst: master ack keeps the pointer running to the next offset
    start_c;
    xbyte({DEVICE_ADDR, 1'h0}, 1'h1, q, k);
    xbyte(OFS_NOISE_LVL, 1'h1, q, k);
    start_c;
    xbyte({DEVICE_ADDR, 1'h1}, 1'h1, q, k);
    xbyte(8'hFF, 1'h0, q, k);
    chk("burst first", q, st[1]);
    xbyte(8'hFF, 1'h1, q, k);
    chk("burst second", q, st[2]);
    stop_c;
    reg_wr(OFS_ACK_LOW, 8'h5A);
    chk("ack low", event_ack_low, 8'h5A);
    reg_wr(OFS_ACK_HIGH, 8'hFF);
    chk("ack high", event_ack_high, 2'h3);
    reg_rd(8'h90, q);
    chk("unmapped", q, 8'h00);
    start_c;
    xbyte({~DEVICE_ADDR, 1'h0}, 1'h1, q, k);
    chk("foreign addr", k, 1'h1);
    stop_c;
    $display("test registers done");
    final_report;
  end
endmodule

`default_nettype wire
